// [rtl/lrs_regs.vh]
// Constants for the indicator, reset and strap block.
// Assumes a 25 MHz pclk and an APB register port with 32-bit data.
`ifndef LRS_REGS_VH
`define LRS_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define LRS_OFF_CTRL 12'h000
`define LRS_OFF_STATUS 12'h004

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LRS_CTRL_ADDR_LSB 0
`define LRS_CTRL_ADDR_MSB 4
`define LRS_CTRL_MODE_BIT 8
`define LRS_ST_ISOLATE_BIT 0
`define LRS_ST_LINK_BIT 1
`define LRS_ST_SPEED_BIT 2
`define LRS_ST_LINKIND_BIT 3
`define LRS_ST_SPEEDIND_BIT 4
`define LRS_ST_STRAP_LSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LRS_ADDR_RST 5'h01
`define LRS_MODE_RST 1'b0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LRS_CLK_MHZ 25
`define LRS_RESET_MIN_NS 1000
// Cycles of pclk in the minimum reset pulse: 1000 ns at 25 MHz.
`define LRS_RESET_MIN_CYC 8'd25
`define LRS_BLINK_CYC 24'h2FAF08
`define LRS_BLINK_HALF 24'h17D784

`endif

// [rtl/lrs_top.v]
// Link and speed indicators, hardware reset qualifier and strap capture.
// Assumes strap pins and reset come from the board asynchronously.
//
// Operation
// - Mode 1: link indicator on when link good, else off.
// - Mode 2: link indicator on with good link, blinks on activity.
// - Speed indicator on at 100 Mb/s, off at 10 Mb/s.
// - Speed indicator ignores the indicator mode.
// - Reset pin low for at least 1 us starts a full reset.
// - Hardware reset restores register defaults and re-samples straps.
// - Strap pin levels sampled during reset set the station address and isolate mode.
// - Strap capture finishes before pins return to normal output use.
// - Five-bit station address latched from straps into control word.
// - Any strapped address 0 to 31 is accepted.
// - Strapped address zero puts the device in isolate mode.
// - Writing address zero by register does not enter isolate mode.
`timescale 1ns/1ps
`include "lrs_regs.vh"

module lrs_top (
  input wire pclk,
  input wire presetn,
  input wire hw_reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire link_good,
  input wire speed_100,
  input wire activity,
  input wire [4:0] station_address_strap,
  output reg link_indicator,
  output reg speed_indicator,
  output reg strap_drive_enable,
  output reg isolate,
  output reg device_reset_n,
  output wire [4:0] device_control_word
);

  // ----------------------------------------------------------------------
  // Reset pin qualifier
  // ----------------------------------------------------------------------
  localparam [7:0] RST_MIN = `LRS_RESET_MIN_CYC;
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_LOW = 2'd1;
  localparam [1:0] ST_CAPT = 2'd2;

  reg [2:0] rst_sync;
  reg rst_level;
  reg [1:0] state;
  reg [7:0] low_cnt;
  reg [1:0] next_state;

  // The first stage feeds only the second; a change counts when the
  // second and third stages agree.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync <= 3'b111;
      rst_level <= 1'b1;
    end else begin
      rst_sync <= {rst_sync[1:0], hw_reset_n};
      if (rst_sync[1] == rst_sync[2])
        rst_level <= rst_sync[2];
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: if (!rst_level) next_state = ST_LOW;
      ST_LOW: begin
        if (rst_level)
          next_state = (low_cnt >= RST_MIN) ? ST_CAPT : ST_RUN;
      end
      ST_CAPT: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_CAPT;
      low_cnt <= 8'h00;
    end else begin
      state <= next_state;
      if (state == ST_LOW && low_cnt != 8'hFF)
        low_cnt <= low_cnt + 8'h01;
      else if (state != ST_LOW)
        low_cnt <= 8'h00;
    end
  end

  // A short glitch on the pin is ignored; a qualified low resets the indicator mode
  // and holds the device once it has lasted RST_MIN cycles, while the pin is still low.
  wire soft_rst = (state == ST_LOW) && (low_cnt >= RST_MIN);
  wire capture = (state == ST_CAPT);

  // ----------------------------------------------------------------------
  // Strap capture and control registers
  // ----------------------------------------------------------------------
  reg [4:0] strap_level;
  reg [4:0] strap_value;
  reg [4:0] station_addr;
  reg led_mode;
  integer i;
  // Three-stage synchronisers for the five strap pins.
  reg [4:0] s1_a, s1_b, s2_b;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_level <= `LRS_ADDR_RST;
    end else begin
      for (i = 0; i < 5; i = i + 1) begin
        if (s1_b[i] == s2_b[i])
          strap_level[i] <= s2_b[i];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_a <= `LRS_ADDR_RST;
      s1_b <= `LRS_ADDR_RST;
      s2_b <= `LRS_ADDR_RST;
    end else begin
      s1_a <= station_address_strap;
      s1_b <= s1_a;
      s2_b <= s1_b;
    end
  end

  wire wr = psel && penable && pwrite;
  wire mapped = (paddr == `LRS_OFF_CTRL) || (paddr == `LRS_OFF_STATUS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_value <= `LRS_ADDR_RST;
      station_addr <= `LRS_ADDR_RST;
      led_mode <= `LRS_MODE_RST;
      isolate <= 1'b0;
      strap_drive_enable <= 1'b0;
      device_reset_n <= 1'b0;
    end else if (soft_rst) begin
      // Only a qualified pulse holds the device; a glitch leaves it running.
      led_mode <= `LRS_MODE_RST;
      strap_drive_enable <= 1'b0;
      device_reset_n <= 1'b0;
    end else if (capture) begin
      // All values 0 to 31 are legal addresses.
      strap_value <= strap_level;
      station_addr <= strap_level;
      isolate <= (strap_level == 5'h00);
      led_mode <= `LRS_MODE_RST;
      strap_drive_enable <= 1'b0;
      device_reset_n <= 1'b0;
    end else begin
      strap_drive_enable <= 1'b1;
      device_reset_n <= 1'b1;
      if (wr && paddr == `LRS_OFF_CTRL) begin
        // Isolation is not touched here, so address zero by write is
        // only an address.
        station_addr <= pwdata[`LRS_CTRL_ADDR_MSB:`LRS_CTRL_ADDR_LSB];
        led_mode <= pwdata[`LRS_CTRL_MODE_BIT];
      end
    end
  end

  assign device_control_word = station_addr;

  // ----------------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------------
  reg [2:0] ls0;
  reg [1:0] link_q, spd_q, act_q;
  reg link_s, spd_s, act_s;
  reg [23:0] blink_cnt;

  // Status pins pass the same three-stage filter as the strap pins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls0 <= 3'b000;
      link_q <= 2'b00;
      spd_q <= 2'b00;
      act_q <= 2'b00;
      link_s <= 1'b0;
      spd_s <= 1'b0;
      act_s <= 1'b0;
    end else begin
      ls0 <= {activity, speed_100, link_good};
      link_q <= {link_q[0], ls0[0]};
      spd_q <= {spd_q[0], ls0[1]};
      act_q <= {act_q[0], ls0[2]};
      if (link_q[0] == link_q[1]) link_s <= link_q[1];
      if (spd_q[0] == spd_q[1]) spd_s <= spd_q[1];
      if (act_q[0] == act_q[1]) act_s <= act_q[1];
    end
  end

  // A blink lasts a whole period so short bursts remain visible; the
  // indicator goes dark in the first half so activity shows at once.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= 24'h000000;
      link_indicator <= 1'b0;
      speed_indicator <= 1'b0;
    end else begin
      if (blink_cnt != 24'h000000)
        blink_cnt <= blink_cnt - 24'h000001;
      else if (act_s && led_mode)
        blink_cnt <= `LRS_BLINK_CYC;
      if (!led_mode)
        link_indicator <= link_s;
      else
        link_indicator <= link_s &&
          !(blink_cnt >= `LRS_BLINK_HALF);
      speed_indicator <= spd_s;
    end
  end

  // ----------------------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always @* begin
    prdata = 32'h00000000;
    if (paddr == `LRS_OFF_CTRL) begin
      prdata[`LRS_CTRL_ADDR_MSB:`LRS_CTRL_ADDR_LSB] = station_addr;
      prdata[`LRS_CTRL_MODE_BIT] = led_mode;
    end else if (paddr == `LRS_OFF_STATUS) begin
      prdata[`LRS_ST_ISOLATE_BIT] = isolate;
      prdata[`LRS_ST_LINK_BIT] = link_s;
      prdata[`LRS_ST_SPEED_BIT] = spd_s;
      prdata[`LRS_ST_LINKIND_BIT] = link_indicator;
      prdata[`LRS_ST_SPEEDIND_BIT] = speed_indicator;
      prdata[`LRS_ST_STRAP_LSB+4:`LRS_ST_STRAP_LSB] = strap_value;
    end
  end

endmodule

// [dv/lrs_top_asserts.sv]
// Checker for the indicator, reset and strap block.
// Assumes it is bound to lrs_top and sees only its ports.
`timescale 1ns/1ps
module lrs_chk (
  input wire pclk,
  input wire presetn,
  input wire hw_reset_n,
  input wire link_good,
  input wire speed_100,
  input wire activity,
  input wire link_indicator,
  input wire speed_indicator,
  input wire strap_drive_enable,
  input wire isolate,
  input wire device_reset_n,
  input wire [4:0] device_control_word
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] low_cnt;
  // Counts raw low cycles of the reset pin, saturating.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= 6'h00;
    else if (hw_reset_n) low_cnt <= 6'h00;
    else if (low_cnt != 6'h3F) low_cnt <= low_cnt + 6'h01;
  end
  sequence capture_done;
    $rose(strap_drive_enable) ##2 1'b1;
  endsequence
  a_dark_no_link: assert property (!link_good [*8] |-> !link_indicator)
    else $error("link indicator lit without link");
  a_link_lit: assert property
    ((link_good && !activity && device_reset_n) [*8] |-> link_indicator)
    else $error("link indicator dark with quiet good link");
  a_speed_on: assert property
    ((speed_100 && device_reset_n) [*8] |-> speed_indicator)
    else $error("speed indicator dark at 100");
  a_speed_off: assert property (!speed_100 [*8] |-> !speed_indicator)
    else $error("speed indicator lit at 10");
  a_iso_capture: assert property
    (capture_done |-> isolate == (device_control_word == 5'h00))
    else $error("isolate does not match captured address");
  a_iso_stable: assert property (strap_drive_enable [*3] |-> $stable(isolate))
    else $error("isolate changed outside capture");
  a_strap_hold: assert property (!device_reset_n |-> !strap_drive_enable)
    else $error("pins released while in reset");
  a_reset_len: assert property ($fell(device_reset_n) |-> low_cnt >= 6'd25)
    else $error("short reset pulse accepted");
  a_reset_taken: assert property (low_cnt == 6'd40 |-> !device_reset_n)
    else $error("long reset pulse ignored");
endmodule

// [dv/lrs_board.sv]
// Board model: strap resistors and the reset button.
// Assumes its task is called right after a pclk edge.
`timescale 1ns/1ps
module lrs_board (
  input wire pclk,
  output logic hw_reset_n,
  output logic [4:0] station_address_strap
);
  logic fitted = 1'b0;
  logic [4:0] strap = 5'h00;
  // Unfitted pins rest on the weak pulls: bit 0 up, the rest down.
  always @* station_address_strap = fitted ? strap : 5'h01;
  initial hw_reset_n = 1'b1;
  task automatic press(input logic fit, input logic [4:0] val, input int n);
    fitted <= fit;
    strap <= val;
    hw_reset_n <= 1'b0;
    repeat (n) @(posedge pclk);
    hw_reset_n <= 1'b1;
  endtask
endmodule

// [dv/test_led_reset_strap_logic.sv]
// Self-checking bench for the indicator, reset and strap block.
// Assumes the board model supplies the straps and the reset pin.
`timescale 1ns/1ps
`include "lrs_regs.vh"
module test_led_reset_strap_logic;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, link_good = 1'b0, speed_100 = 1'b0;
  logic activity = 1'b0, hw_reset_n, link_indicator, speed_indicator;
  logic strap_drive_enable, isolate, device_reset_n;
  logic [4:0] station_address_strap, device_control_word;
  logic [4:0] addrs [4] = '{5'h00, 5'h1F, 5'h15, 5'h01};
  int failures = 0, samples_checked = 0;
  always #20 pclk = ~pclk;
  lrs_board board (.pclk(pclk), .hw_reset_n(hw_reset_n),
    .station_address_strap(station_address_strap));
  lrs_top uut (.*);
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    wt(1);
    penable <= 1'b1;
    wt(1);
    for (int n = 0; n < 20 && pready !== 1'b1; n++) wt(1);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    wt(1);
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    wt(5);
    presetn <= 1'b1;
    wt(3);
    apb(0, `LRS_OFF_CTRL, 0);
    chk(rd, 32'h1, "default address");
    apb(0, `LRS_OFF_STATUS, 0);
    chk(rd & 32'h1F01, 32'h0100, "default status");
    apb(0, 12'h010, 0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("defaults test done");
    for (int m = 0; m < 2; m++) begin
      activity <= ~m[0];
      wt(8);
      apb(1, `LRS_OFF_CTRL, {23'h0, m[0], 8'h01});
      for (int s = 0; s < 4; s++) begin
        link_good <= s[1];
        speed_100 <= s[0];
        wt(8);
        chk({30'h0, link_indicator, speed_indicator}, s, "leds");
      end
    end
    activity <= 1'b1;
    wt(8);
    chk({30'h0, link_indicator, speed_indicator}, 32'h1, "mode 2 act");
    $display("indicator test done");
    apb(1, `LRS_OFF_CTRL, 32'h100);
    wt(3);
    chk({26'h0, isolate, device_control_word}, 32'h0, "write zero");
    for (int i = 0; i < 4; i++) begin
      apb(1, `LRS_OFF_CTRL, 32'h100);
      board.press(i < 3, addrs[i], 40);
      for (int n = 0; n < 60 && strap_drive_enable !== 1'b1; n++) wt(1);
      wt(3);
      chk({26'h0, isolate, device_control_word},
        {26'h0, addrs[i] == 5'h00, addrs[i]}, "capture");
      apb(0, `LRS_OFF_CTRL, 0);
      chk(rd, {27'h0, addrs[i]}, "control after reset");
    end
    $display("strap test done");
    board.press(1, 5'h0A, 10);
    wt(40);
    chk({26'h0, device_reset_n, device_control_word}, 32'h21, "short");
    $display("short pulse test done");
    report_and_stop();
  end
  initial begin
    #200us;
    failures++;
    report_and_stop();
  end
endmodule
bind lrs_top lrs_chk chk (.*);
